// >>> verilog/four_master_priority_arbiter.sv
// Four-master fixed-priority bus arbiter with bus lock
// What this block does
// - Four active-low request lines, one per master
// - Line zero always wins, line three loses
// - Owner holds lock low while using bus
// - No new grant while lock is low
// - One active-low grant output per master
// - Hold grant under lock; drop on higher request
// - Preempting master waits for lock release
// - Low reset initialises all arbitration state
`timescale 1ns/1ps
`default_nettype none
`include "arb_map.svh"

module four_master_priority_arbiter
   import arb_pkg::*;
#(
   parameter int N = `ARB_MASTERS
) (
   // Clock and synchronous reset
   input  wire logic         clk_sys,
   input  wire logic         rst_n,
   // Master request and shared lock pins
   input  wire logic [N-1:0] bus_req_n,
   input  wire logic         bus_lock_n,
   // Grant pins, one per master
   output var  logic [N-1:0] bus_gnt_n
);

   localparam int IW = (N > 1) ? $clog2(N) : 1;  // Owner index width

   logic [N-1:0]  req_m;      // Request synchroniser, first stage
   logic [N-1:0]  req_n_s;    // Request synchroniser, second stage
   logic          lock_m;     // Lock synchroniser, first stage
   logic          lock_n_s;   // Lock synchroniser, second stage
   logic [N-1:0]  req_s;      // Requests, active high
   logic          lock_s;     // Bus occupied, active high
   logic [N-1:0]  gnt;        // Grants, active high
   logic [IW-1:0] owner;      // Index of the granted master
   arb_state_e    state;      // Sequencer state

   // Carrier to the priority picker
   arb_pick_if #(.N(N), .IW(IW)) pick_bus ();

   // Priority picker
   arb_pick #(.N(N), .IW(IW)) u_pick (
      .p (pick_bus.pick)
   );

   // Pin synchronisers; idle level after reset
   // Request and lock pins come from other masters with no timing relation
   // to this clock, so logic reads only the second stage; the reset value
   // is the idle pin level so no request appears out of reset
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         req_m    <= {N{`ARB_LINE_IDLE}};
         req_n_s  <= {N{`ARB_LINE_IDLE}};
         lock_m   <= `ARB_LINE_IDLE;
         lock_n_s <= `ARB_LINE_IDLE;
      end else begin
         req_m    <= bus_req_n;
         req_n_s  <= req_m;
         lock_m   <= bus_lock_n;
         lock_n_s <= lock_m;
      end
   end

   // Active-high views of the synchronised pins
   assign req_s  = ~req_n_s;
   assign lock_s = ~lock_n_s;
   assign gnt    = ~bus_gnt_n;

   // Feed the picker
   assign pick_bus.req       = req_s;
   assign pick_bus.owner     = owner;
   assign pick_bus.has_owner = (state == ST_OWNED);

   // Grant sequencer: grants, owner and state move together
   // A preempted owner is never handed straight to the new master: the
   // sequencer parks in ST_WAIT, returns to ST_IDLE once lock clears and
   // only then picks again, which leaves at least two idle cycles between grants
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state     <= ST_IDLE;
         owner     <= '0;
         bus_gnt_n <= {N{`ARB_LINE_IDLE}};
      end else begin
         case (state)
            // Bus free of grants; give one only once lock is released
            ST_IDLE: begin
               if (!lock_s && pick_bus.valid) begin
                  state     <= ST_OWNED;
                  owner     <= pick_bus.idx;
                  bus_gnt_n <= ~({{(N-1){1'b0}}, 1'b1} << pick_bus.idx);
               end
            end
            // Owner holds the bus
            ST_OWNED: begin
               if (pick_bus.higher) begin
                  // Higher master appeared: withdraw now, grant later
                  state     <= ST_WAIT;
                  bus_gnt_n <= {N{`ARB_LINE_IDLE}};
               end else if (!lock_s && !req_s[owner]) begin
                  // Owner done and not locking: release the bus
                  state     <= ST_IDLE;
                  bus_gnt_n <= {N{`ARB_LINE_IDLE}};
               end
            end
            // Preempted owner still locks; hold every grant off
            ST_WAIT: begin
               if (!lock_s) begin
                  state <= ST_IDLE;
               end
            end
            // Unused code returns to idle
            default: begin
               state     <= ST_IDLE;
               bus_gnt_n <= {N{`ARB_LINE_IDLE}};
            end
         endcase
      end
   end

   // Checks below hold the grant pins against the sequencer and the
   // synchronised pins; all of them sample on the rising clock edge

   // Reset leaves every grant inactive at the next edge
   a_reset_idle_gnt: assert property (@(posedge clk_sys) !rst_n |=> &bus_gnt_n)
      else $error("grant active after reset");

   // Never more than one grant
   a_gnt_one_hot: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $onehot0(gnt))
      else $error("more than one grant active");

   // Grant lines mirror the sequencer state
   a_gnt_state_match: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state == ST_OWNED) == (gnt == ({{(N-1){1'b0}}, 1'b1} << owner)))
      else $error("grant does not match owner");

   // Lock pin held low reaches the internal busy view
   a_lock_sync_path: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!bus_lock_n)[*3] |-> lock_s)
      else $error("lock not seen after two stages");

   // No new grant while lock is asserted
   a_no_grant_lock: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (gnt == '0 && lock_s) |=> gnt == '0)
      else $error("grant issued under lock");

   // Free bus goes to the highest-priority requester
   a_prio_winner: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state == ST_IDLE && gnt == '0 && !lock_s && pick_bus.valid)
      |=> gnt == ({{(N-1){1'b0}}, 1'b1} << $past(pick_bus.idx)))
      else $error("grant not to highest requester");

   // Without requests no grant appears
   a_no_req_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (gnt == '0 && !pick_bus.valid) |=> gnt == '0)
      else $error("grant without request");

   // Owner keeps the grant under lock unless preempted; drops when preempted
   a_hold_or_drop: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state == ST_OWNED && lock_s)
      |=> ($past(pick_bus.higher) ? gnt == '0 : $stable(gnt)))
      else $error("owner grant wrong under lock");

   // Preempting master stays ungranted until lock releases
   a_wait_release: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state == ST_WAIT && lock_s) |=> gnt == '0 ##0 state == ST_WAIT)
      else $error("grant given before lock release");

   // Requests reach the picker exactly two edges after the pins
   a_req_sync_path: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ($past(rst_n) && $past(rst_n, 2)) |-> req_s == ~$past(bus_req_n, 2))
      else $error("request not seen after two stages");

   // Lock pin held high reads as a free bus
   a_lock_free_path: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (bus_lock_n)[*3] |-> !lock_s)
      else $error("lock release not seen after two stages");

   // A fresh grant goes to a master that was requesting
   a_gnt_needs_req: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (gnt == '0) ##1 (gnt != '0) |-> (gnt & $past(req_s)) != '0)
      else $error("grant to a master that did not request");

   // No line numbered below a fresh grant was requesting
   a_prio_lowest_line: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (gnt == '0) ##1 (gnt != '0)
      |-> ($past(req_s) & (gnt - {{(N-1){1'b0}}, 1'b1})) == '0)
      else $error("grant passed over a higher requester");

   // Owner keeps the bus while it locks and nobody above asks
   a_owner_held: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state == ST_OWNED && lock_s && !pick_bus.higher) |=> state == ST_OWNED)
      else $error("owner lost the bus under lock");

   // Owner done with the lock released gives the bus back
   a_release_free: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state == ST_OWNED && !pick_bus.higher && !lock_s && !req_s[owner]) |=> gnt == '0)
      else $error("grant kept after release");

   // Higher request withdraws the grant whatever the lock does
   a_drop_on_higher: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state == ST_OWNED && pick_bus.higher) |=> (gnt == '0 && state == ST_WAIT))
      else $error("grant kept despite higher request");

   // Lock release after preemption returns to idle without a grant
   a_wait_to_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state == ST_WAIT && !lock_s) |=> (state == ST_IDLE && gnt == '0))
      else $error("wait state left wrongly");

   // Grant lines only hold or clear; a handoff passes through idle
   a_handoff_gap: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (gnt != '0) |=> (gnt == '0 || $stable(gnt)))
      else $error("grant moved without an idle cycle");

   // Reset clears the sequencer and both synchroniser views
   a_reset_state: assert property (@(posedge clk_sys)
      !rst_n |=> (state == ST_IDLE && req_s == '0 && !lock_s))
      else $error("state not cleared by reset");

endmodule

`default_nettype wire

// >>> verilog/arb_map.svh
// Constant map for the four-master priority arbiter
`ifndef ARB_MAP_SVH
`define ARB_MAP_SVH

// Number of masters on the shared bus
`define ARB_MASTERS 4
// Flip-flops in each pin synchroniser
`define ARB_SYNC_STAGES 2
// Inactive level of an active-low line
`define ARB_LINE_IDLE 1'b1

`endif

// >>> verilog/arb_pkg.sv
// Types shared by the arbiter modules
`default_nettype none

package arb_pkg;

   // Arbitration sequencer states
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_OWNED,
      ST_WAIT
   } arb_state_e;

endpackage

`default_nettype wire

// >>> verilog/arb_pick_if.sv
// Carrier between the arbiter core and its priority picker
`timescale 1ns/1ps
`default_nettype none

interface arb_pick_if #(
   parameter int N  = 4,
   parameter int IW = 2
);
   logic [N-1:0]  req;        // Synchronised requests, active high
   logic [IW-1:0] owner;      // Index of the present owner
   logic          has_owner;  // A grant is presently out
   logic          valid;      // Some master requests
   logic [IW-1:0] idx;        // Highest-priority requester
   logic          higher;     // A master above the owner requests

   // Core side
   modport core (output req, output owner, output has_owner,
                 input valid, input idx, input higher);
   // Picker side
   modport pick (input req, input owner, input has_owner,
                 output valid, output idx, output higher);
endinterface

`default_nettype wire

// >>> verilog/arb_pick.sv
// Fixed-priority picker: line zero wins, highest line loses
`timescale 1ns/1ps
`default_nettype none

module arb_pick #(
   parameter int N  = 4,
   parameter int IW = 2
) (
   // Picker side of the carrier
   arb_pick_if.pick p
);

   // Scan from lowest priority up so line zero overrides all
   always_comb begin
      p.valid = 1'b0;
      p.idx   = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (p.req[i]) begin
            p.valid = 1'b1;
            p.idx   = IW'(i);
         end
      end
   end

   // Any request on a line numbered below the owner preempts it
   always_comb begin
      p.higher = 1'b0;
      for (int i = 0; i < N; i++) begin
         if (p.has_owner && p.req[i] && (i < int'(p.owner))) begin
            p.higher = 1'b1;
         end
      end
   end

endmodule

`default_nettype wire

// >>> verif/bus_masters.sv
// Behavioural model of the four bus masters facing the arbiter
`timescale 1ns/1ps
`default_nettype none

module bus_masters (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   // Bench control: who asks, who wants the bus locked
   input  wire logic [3:0] want,
   input  wire logic [3:0] use_bus,
   // Pins towards the arbiter
   input  wire logic [3:0] bus_gnt_n,
   output var  logic [3:0] bus_req_n,
   output var  logic       bus_lock_n
);
   logic [3:0] own;  // Master that last held a grant

   // Each master pulls its own request line low
   assign bus_req_n = ~want;
   // Only the last owner drives the lock, and keeps it through preemption
   assign bus_lock_n = ~|(own & use_bus);

   // Remember the owner once its grant shows
   always @(negedge clk_sys) begin
      if (!rst_n) begin
         own <= 4'h0;
      end else if (bus_gnt_n != 4'hF) begin
         own <= ~bus_gnt_n;
      end else if ((own & use_bus) == 4'h0) begin
         // Bus idle and no lock pending: nobody owns it any more
         own <= 4'h0;
      end
   end
endmodule

`default_nettype wire

// >>> verif/four_master_priority_arbiter_tb.sv
// Self-checking bench for the four-master priority arbiter
`timescale 1ns/1ps
`default_nettype none

module four_master_priority_arbiter_tb;
   logic       clk_sys = 1'b0;  // 20 MHz system clock
   logic       rst_n = 1'b0;    // Synchronous reset, active low
   logic [3:0] want = 4'h0;     // Masters asking for the bus
   logic [3:0] use_bus = 4'h0;  // Masters that lock while owning
   logic [3:0] bus_req_n;       // Request pins
   logic       bus_lock_n;      // Lock pin
   logic [3:0] bus_gnt_n;       // Grant pins
   logic [3:0] last = 4'hF;     // Last grant value noted
   logic [3:0] w;               // Random request mask
   logic [3:0] q[$];            // Expected grant changes
   int         n_mismatch = 0;  // Mismatches seen
   int         checked = 0;     // Comparisons made

   // Design and partner
   four_master_priority_arbiter dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
      .bus_req_n(bus_req_n), .bus_lock_n(bus_lock_n), .bus_gnt_n(bus_gnt_n));
   bus_masters mst_u (.clk_sys(clk_sys), .rst_n(rst_n), .want(want), .use_bus(use_bus),
      .bus_gnt_n(bus_gnt_n), .bus_req_n(bus_req_n), .bus_lock_n(bus_lock_n));

   // Clock, 50 ns period
   initial begin
      forever #25 clk_sys = ~clk_sys;
   end

   // Compare one value
   task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Print counts and verdict, then stop
   task automatic complete_run;
      $display("mismatches %0d, comparisons %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Drive pins, note the expected grant, check it n edges later
   task automatic go(input logic [3:0] r, input logic [3:0] u, input logic [3:0] e,
                     input int n);
      want <= r;
      use_bus <= u;
      if (e !== last) begin
         q.push_back(e);
         last = e;
      end
      repeat (n) @(posedge clk_sys);
      @(negedge clk_sys);
      chk(bus_gnt_n, e);
   endtask

   // Every grant change must match the oldest note
   always @(bus_gnt_n) begin
      if (rst_n === 1'b1) begin
         if (q.size() == 0) begin
            chk(bus_gnt_n, last);
         end else begin
            chk(bus_gnt_n, q.pop_front());
         end
      end
   end

   // Watchdog against a hang
   initial begin
      repeat (5000) @(posedge clk_sys);
      n_mismatch++;
      complete_run();
   end

   // Main sequence
   initial begin
      void'($urandom(32'h5a7ab920));
      repeat (6) @(posedge clk_sys);
      @(negedge clk_sys);
      chk(bus_gnt_n, 4'hF);
      rst_n <= 1'b1;
      // Lone request from each master, then release
      for (int i = 0; i < 4; i++) begin
         go(4'h1 << i, 4'h0, ~(4'h1 << i), 3);
         go(4'h0, 4'h0, 4'hF, 3);
      end
      // Random contention on an idle bus: lowest line wins
      for (int k = 0; k < 8; k++) begin
         w = 4'($urandom % 15 + 1);
         go(w, 4'h0, ~(w & (~w + 4'h1)), 3);
         go(4'h0, 4'h0, 4'hF, 3);
      end
      // Locked ownership, lower request, preemption, late handover
      go(4'b0100, 4'b0100, 4'b1011, 3);
      go(4'b0000, 4'b0100, 4'b1011, 4);
      go(4'b1000, 4'b0100, 4'b1011, 4);
      go(4'b1001, 4'b0100, 4'hF, 3);
      go(4'b1001, 4'b0100, 4'hF, 6);
      go(4'b1001, 4'b0000, 4'hF, 3);
      go(4'b1001, 4'b0000, 4'b1110, 1);
      go(4'b0000, 4'b0000, 4'hF, 3);
      // Reset in mid-run while a grant is out, then a fresh grant
      go(4'b0010, 4'h0, 4'b1101, 3);
      rst_n <= 1'b0;
      repeat (2) @(negedge clk_sys);
      chk(bus_gnt_n, 4'hF);
      last = 4'hF;
      rst_n <= 1'b1;
      go(4'b0010, 4'h0, 4'b1101, 3);
      go(4'h0, 4'h0, 4'hF, 3);
      // Let outstanding notes drain
      for (int t = 0; t < 20 && q.size() != 0; t++) begin
         @(posedge clk_sys);
      end
      if (q.size() != 0) begin
         n_mismatch++;
      end
      complete_run();
   end
endmodule

`default_nettype wire
